// >>> rtl/dram_ctrl_map.vh
// Timing and geometry constants for the 16k x 1 dynamic RAM controller.
// Assumes a 25 MHz system clock; counts derive from times in ns.
`ifndef DRAM_CTRL_MAP_VH
`define DRAM_CTRL_MAP_VH
`define CLK_PERIOD_NS       40
`define ADDR_HALF_W         7
`define ROW_COUNT           128
// Refresh period 2 ms, spread as one row cycle per slot
`define REFRESH_PERIOD_NS   2000000
`define REFRESH_SLOT_CYC    ((`REFRESH_PERIOD_NS / `ROW_COUNT) / `CLK_PERIOD_NS)
`define WARMUP_CYCLES       8
// Strobe phase minimum times in ns, rounded up to cycles
`define ROW_SETUP_NS        40
`define ROW_TO_COL_NS       80
`define COL_ACCESS_NS       160
`define PRECHARGE_NS        120
`define NS_TO_CYC(t)        (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_SETUP_CYC       `NS_TO_CYC(`ROW_SETUP_NS)
`define ROW_TO_COL_CYC      `NS_TO_CYC(`ROW_TO_COL_NS)
`define COL_ACCESS_CYC      `NS_TO_CYC(`COL_ACCESS_NS)
`define PRECHARGE_CYC       `NS_TO_CYC(`PRECHARGE_NS)
`endif

// >>> rtl/dram_ctrl.v
// Controller for a 16k x 1 multiplexed-address dynamic RAM.
// Assumes the RAM sits on the strobe pins; data out pin sampled synchronously.
//
// Functional notes
// - Row and column halves share the address pins, each with own strobe.
// - Controller refreshes every cell at least every 2 ms.
// - Each row strobe cycle refreshes one row; 128 distinct rows per period.
// - Controller runs warm-up cycles after power-up reset only; a missed refresh does not restart them.
// - Address stable at row strobe fall.
// - Address stable at column strobe fall.
// - In reads, write strobe stays high while column strobe is low.
// - Early write: write strobe falls in the same cycle as column strobe; output released.
// - Page mode keeps row strobe low while column strobe cycles; not used here, row strobe rises with each column.
// - At least 8 row strobe cycles after power-up before use.
`timescale 1ns/1ps
`include "dram_ctrl_map.vh"

module dram_ctrl #(
  parameter REFRESH_SLOT = `REFRESH_SLOT_CYC  // Cycles between refresh rows
) (
  input  wire        sys_clk_i,    // System clock, 25 MHz
  input  wire        resetn_i,     // Synchronous reset, active low
  input  wire        req_i,        // Access request, level, taken when ready
  input  wire        we_i,         // 1 write, 0 read
  input  wire [13:0] addr_i,       // Word address, row in upper half
  input  wire        wdata_i,      // Write data bit
  output reg         ready_o,      // Idle and warmed up, accepts request
  output reg         rdata_o,      // Read data bit
  output reg         rvalid_o,     // One-cycle pulse with read data
  output reg         wdone_o,      // One-cycle pulse when write ends
  output reg         row_strobe_n_o, // Row address strobe, active low
  output reg         col_strobe_n_o, // Column address strobe, active low
  output reg         write_n_o,    // Write strobe, active low
  output reg  [6:0]  mem_addr_o,   // Multiplexed address pins
  output reg         data_input_o, // To device data input pin
  input  wire        data_out_i    // From device data output pin
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ROW  = 7'h02;
  localparam [6:0] S_RCD  = 7'h04;
  localparam [6:0] S_COL  = 7'h08;
  localparam [6:0] S_PRE  = 7'h10;
  localparam [6:0] S_REF  = 7'h20;
  localparam [6:0] S_RSET = 7'h40;
  localparam [15:0] SLOT  = REFRESH_SLOT[15:0];

  reg [6:0]  state_q;
  reg [7:0]  wait_q;
  reg [15:0] ref_cnt_q;
  reg        ref_due_q;
  reg [6:0]  ref_row_q;
  reg [3:0]  warm_q;
  reg        we_q;
  reg [6:0]  col_q;

  // Cycle counts as 8-bit values for the phase timer
  function [7:0] cyc;
    input integer n;
    begin
      cyc = n[7:0];
    end
  endfunction

  // Refresh slot timer; a due flag survives a busy access so no slot is lost
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ref_cnt_q <= 16'h0000;
      ref_due_q <= 1'b0;
    end else begin
      if (ref_cnt_q >= SLOT - 16'h0001) begin
        ref_cnt_q <= 16'h0000;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 16'h0001;
        if (state_q == S_REF && wait_q == 8'h00)
          ref_due_q <= 1'b0;
      end
    end
  end

  // Strobe sequencer; refresh wins over a pending request
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_q        <= S_IDLE;
      wait_q         <= 8'h00;
      ref_row_q      <= 7'h00;
      warm_q         <= 4'h0;
      we_q           <= 1'b0;
      col_q          <= 7'h00;
      ready_o        <= 1'b0;
      rdata_o        <= 1'b0;
      rvalid_o       <= 1'b0;
      wdone_o        <= 1'b0;
      row_strobe_n_o <= 1'b1;
      col_strobe_n_o <= 1'b1;
      write_n_o      <= 1'b1;
      mem_addr_o     <= 7'h00;
      data_input_o   <= 1'b0;
    end else begin
      rvalid_o <= 1'b0;
      wdone_o  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (ref_due_q || warm_q < `WARMUP_CYCLES) begin
            ready_o    <= 1'b0;
            mem_addr_o <= ref_row_q;
            wait_q     <= cyc(`ROW_SETUP_CYC);
            state_q    <= S_RSET;
          end else if (req_i && ready_o) begin
            ready_o      <= 1'b0;
            we_q         <= we_i;
            col_q        <= addr_i[6:0];
            mem_addr_o   <= addr_i[13:7];
            data_input_o <= wdata_i;
            wait_q       <= cyc(`ROW_SETUP_CYC);
            state_q      <= S_ROW;
          end else begin
            ready_o <= 1'b1;
          end
        end
        S_RSET: begin
          if (wait_q > 8'h01) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            row_strobe_n_o <= 1'b0;  // Row-only cycle, column strobe held high
            wait_q         <= cyc(`COL_ACCESS_CYC + `ROW_TO_COL_CYC);
            state_q        <= S_REF;
          end
        end
        S_REF: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            row_strobe_n_o <= 1'b1;
            ref_row_q      <= ref_row_q + 7'h01;
            if (warm_q < `WARMUP_CYCLES)
              warm_q <= warm_q + 4'h1;
            wait_q  <= cyc(`PRECHARGE_CYC);
            state_q <= S_PRE;
          end
        end
        S_ROW: begin
          // Address held from before the fall
          if (wait_q > 8'h01) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            row_strobe_n_o <= 1'b0;
            wait_q         <= cyc(`ROW_TO_COL_CYC);
            state_q        <= S_RCD;
          end
        end
        S_RCD: begin
          if (wait_q > 8'h01) begin
            wait_q <= wait_q - 8'h01;
            if (wait_q == 8'h02)
              mem_addr_o <= col_q;  // Column half ahead of its strobe
          end else begin
            col_strobe_n_o <= 1'b0;
            // Early write: write strobe falls in the same cycle as the column strobe, not before it
            write_n_o      <= ~we_q;
            wait_q         <= cyc(`COL_ACCESS_CYC);
            state_q        <= S_COL;
          end
        end
        S_COL: begin
          if (wait_q > 8'h01) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            // Sample before the column strobe rises and output is released
            if (!we_q) begin
              rdata_o  <= data_out_i;
              rvalid_o <= 1'b1;
            end else begin
              wdone_o <= 1'b1;
            end
            col_strobe_n_o <= 1'b1;
            // Row closes with the column; single-column cycles only
            row_strobe_n_o <= 1'b1;
            write_n_o      <= 1'b1;
            wait_q         <= cyc(`PRECHARGE_CYC);
            state_q        <= S_PRE;
          end
        end
        S_PRE: begin
          // Precharge before the next row fall
          if (wait_q > 8'h01) begin
            wait_q <= wait_q - 8'h01;
          end else begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dram_ctrl

// >>> testbench/dram_ctrl_monitor.sv
// Checker for the RAM controller strobe protocol.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module dram_ctrl_monitor (
  input wire logic       sys_clk_i,      // System clock
  input wire logic       resetn_i,       // Active-low reset
  input wire logic       req_i,          // Access request
  input wire logic       we_i,           // Write select
  input wire logic       ready_o,        // Idle flag
  input wire logic       rvalid_o,       // Read data pulse
  input wire logic       row_strobe_n_o, // Row strobe
  input wire logic       col_strobe_n_o, // Column strobe
  input wire logic       write_n_o,      // Write strobe
  input wire logic [6:0] mem_addr_o,     // Shared address pins
  input wire logic       data_input_o    // Write data pin
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Steps of a read: take, then column fall with write strobe high
  sequence s_rd_take; ready_o && req_i && !we_i; endsequence
  sequence s_col_rd; $fell(col_strobe_n_o) && write_n_o; endsequence
  chk_rd_answer: assert property (s_rd_take ##4 s_col_rd |-> ##4 rvalid_o)
    else $error("read answer missing");
  chk_take_busy: assert property (s_rd_take |=> !ready_o)
    else $error("ready stayed high");
  chk_rd_wstrobe: assert property (s_col_rd |=> write_n_o [*2])
    else $error("write strobe in read");
  chk_row_addr: assert property ($fell(row_strobe_n_o) |-> $stable(mem_addr_o))
    else $error("row address moved");
  chk_col_addr: assert property ($fell(col_strobe_n_o) |-> $stable(mem_addr_o))
    else $error("column address moved");
  chk_col_in_row: assert property ($fell(col_strobe_n_o) |-> !row_strobe_n_o)
    else $error("column strobe outside row");
  chk_write_gated: assert property (!write_n_o |-> !col_strobe_n_o)
    else $error("write strobe without column");
  chk_wdata_hold: assert property ($fell(col_strobe_n_o) && !write_n_o |-> $stable(data_input_o))
    else $error("write data moved");
  chk_row_pulse: assert property ($fell(row_strobe_n_o) |=> !row_strobe_n_o [*3])
    else $error("row strobe too short");
  chk_idle_quiet: assert property (ready_o |-> row_strobe_n_o && col_strobe_n_o)
    else $error("strobe active while idle");
endmodule // dram_ctrl_monitor
bind dram_ctrl dram_ctrl_monitor i_mon (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .req_i(req_i), .we_i(we_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
  .row_strobe_n_o(row_strobe_n_o), .col_strobe_n_o(col_strobe_n_o), .write_n_o(write_n_o),
  .mem_addr_o(mem_addr_o), .data_input_o(data_input_o));

// >>> testbench/ram_model.sv
// Behavioural 16k x 1 dynamic RAM with multiplexed address.
// Assumes strobes come from the controller; no clock of its own.
`timescale 1ns/1ps
module ram_model (
  input wire logic       row_strobe_n_i, // Row strobe
  input wire logic       col_strobe_n_i, // Column strobe
  input wire logic       write_n_i,      // Write strobe
  input wire logic [6:0] mem_addr_i,     // Shared address pins
  input wire logic       data_input_i,   // Write data
  output logic           data_out_o      // Read data, junk when released
);
  logic        cells [0:16383];
  logic [6:0]  row_q;
  logic [13:0] sel_q;
  logic        drive_q = 1'b0;
  logic        last_q = 1'b0;
  // Row open latches and refreshes one of 128 rows
  always @(negedge row_strobe_n_i) row_q = mem_addr_i;
  // Column gated by row; write only inside a column cycle
  always @(negedge col_strobe_n_i) if (!row_strobe_n_i) begin
    sel_q = {row_q, mem_addr_i};
    if (!write_n_i) cells[sel_q] = data_input_i;
    drive_q = write_n_i;
  end
  // Late write strobe inside a column cycle writes after the read part
  always @(negedge write_n_i) if (!col_strobe_n_i && !row_strobe_n_i)
    cells[sel_q] = data_input_i;
  // Released output shows the inverse, so a stale sample is caught
  always @(posedge col_strobe_n_i) begin
    last_q = data_out_o;
    drive_q = 1'b0;
  end
  assign data_out_o = drive_q ? cells[sel_q] : ~last_q;
endmodule // ram_model

// >>> testbench/tb_dram_ctrl.sv
// Self-checking bench for the dynamic RAM controller.
// Assumes dram_ctrl, ram_model and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %0t value mismatch", $time); end end
module tb_dram_ctrl;
  logic        sys_clk_i, resetn_i, req_i, we_i, wdata_i, ready_o, rdata_o, rvalid_o;
  logic        wdone_o, row_n, col_n, wr_n, din, dout;
  logic [13:0] addr_i;
  logic [6:0]  mem_addr;
  logic [31:0] lfsr_q;
  logic [13:0] adr_q [0:31];
  logic        dat_q [0:31];
  int          err_total, comparisons, rows_seen;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Short refresh slot so refresh collides with traffic often
  dram_ctrl #(.REFRESH_SLOT(40)) i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wdone_o(wdone_o), .row_strobe_n_o(row_n),
    .col_strobe_n_o(col_n), .write_n_o(wr_n), .mem_addr_o(mem_addr), .data_input_o(din),
    .data_out_i(dout));
  ram_model i_ram (.row_strobe_n_i(row_n), .col_strobe_n_i(col_n), .write_n_i(wr_n),
    .mem_addr_i(mem_addr), .data_input_i(din), .data_out_o(dout));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge row_n) rows_seen++;
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request held from ready until the answer: a due refresh may win the take edge
  task automatic access(input logic w, input logic [13:0] a, input logic d, input logic e);
    int n;
    n = 0;
    while (!ready_o && n < 500) begin @(posedge sys_clk_i); #1; n++; end
    req_i = 1'b1; we_i = w; addr_i = a; wdata_i = d;
    n = 0;
    do begin @(posedge sys_clk_i); #1; n++; end while (!(rvalid_o | wdone_o) && n < 40);
    req_i = 1'b0; addr_i = ~a; wdata_i = ~d;
    `CHK(n < 40, 1'b1)
    if (!w) `CHK(rdata_o, e)
  endtask
  // Cut a hang short; the whole run needs well under 10000 cycles
  initial begin
    #400000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    resetn_i = 1'b0; req_i = 1'b0; we_i = 1'b0; addr_i = 14'h0000; wdata_i = 1'b0;
    lfsr_q = 32'h06337E26; err_total = 0; comparisons = 0; rows_seen = 0;
    repeat (16) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    // Corner addresses first, then an overwrite of the same bit
    access(1'b1, 14'h0000, 1'b1, 1'b0);
    `CHK(rows_seen >= 8, 1'b1)
    access(1'b1, 14'h3FFF, 1'b0, 1'b0);
    access(1'b0, 14'h0000, 1'b0, 1'b1);
    access(1'b1, 14'h3FFF, 1'b1, 1'b0);
    access(1'b0, 14'h3FFF, 1'b0, 1'b1);
    // Random writes to distinct addresses, idle through refreshes, read back
    for (int i = 0; i < 32; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      adr_q[i] = {lfsr_q[13:5], i[4:0]};
      dat_q[i] = lfsr_q[20];
      access(1'b1, adr_q[i], dat_q[i], 1'b0);
    end
    repeat (300) @(posedge sys_clk_i);
    #1;
    for (int i = 31; i >= 0; i--) access(1'b0, adr_q[i], 1'b0, dat_q[i]);
    tally_and_finish;
  end
endmodule // tb_dram_ctrl
